//--- hdl/ncl_loader.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - host-only words ignore the store
// - mixed words load from store, host overwritable
// - standby setting only from store, default 1
// - cable bleed enable defaults to 0
// - cable supply capability defaults to 1
// - undervoltage level resets to 0
// - reset source select resets to 0
// - safe-zero level defaults to 00
// - init interval fills registers from store
// - load starts on power-on reset release
// - load starts on reset pin release
// - every reset reloads all stored defaults
// - host writes hold until rewrite or reset
module ncl_loader
  import ncl_pkg::*;
(
  // Clock and reset (power-on and pin reset combined outside).
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Store read port, data valid one cycle after address.
  output logic [2:0]      nvm_addr,
  input  wire logic [7:0] nvm_rdata,
  // Host register access.
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wdata,
  output logic [7:0]      host_rdata,
  output logic            host_ack,
  // Status and configuration.
  output logic            load_busy,
  output logic            standby_disable,
  output logic            cable_supply_bleed_on,
  output logic            cable_supply_capability_on,
  output logic            cable_supply_undervolt_level,
  output logic            reset_source_select,
  output logic [1:0]      bus_safe_zero_level
);
  import ncl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Word index to address map; index 7 is the standby word with no host address.
  function automatic logic [7:0] idx_addr(input logic [2:0] i);
    unique case (i)
      3'h0:    idx_addr = ADDR_ALERT_MASK;
      3'h1:    idx_addr = ADDR_CABLE_CTRL;
      3'h2:    idx_addr = ADDR_CABLE_ILIM;
      3'h3:    idx_addr = ADDR_BUS_SHIFT;
      3'h4:    idx_addr = ADDR_DISCH_TIME;
      3'h5:    idx_addr = ADDR_BUS_MON;
      default: idx_addr = 8'hFF;
    endcase
  endfunction

  ncl_state_t state_r;
  logic [2:0] cnt_r;
  logic       rd_pend_r;
  logic [7:0] mixed_r [0:5];
  logic [7:0] cable_mon_r;
  logic [7:0] reset_ctrl_r;
  logic       standby_r;
  logic       idle;

  assign idle = (state_r == NCL_DONE);

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: runs once after each reset release.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r   <= NCL_IDLE;
      cnt_r     <= 3'h0;
      rd_pend_r <= 1'b0;
    end else begin
      unique case (state_r)
        NCL_IDLE: begin
          state_r   <= NCL_LOAD;
          cnt_r     <= 3'h0;
          rd_pend_r <= 1'b1;
        end
        NCL_LOAD: begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'(NVM_WORDS - 1)) begin
            state_r   <= NCL_DONE;
            rd_pend_r <= 1'b0;
          end
        end
        NCL_DONE: state_r <= NCL_DONE;
        // Code 2'b10 is never reached; should it ever be, a fresh load is the safe way out.
        default:  state_r <= NCL_IDLE;
      endcase
    end
  end

  // Address leads the capture by one cycle.
  assign nvm_addr = (state_r == NCL_LOAD) ? 3'(cnt_r + 3'h1) : 3'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Mixed words: loaded from the store, then host writable.
  // Capture and host write never meet, because writes are only taken once idle.
  generate
    for (genvar g = 0; g < 6; g++) begin : g_mixed
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mixed_r[g] <= 8'h00;
        end else if (state_r == NCL_LOAD && rd_pend_r && cnt_r == 3'(g)) begin
          mixed_r[g] <= nvm_rdata;
        end else if (idle && host_wr && host_addr == idx_addr(3'(g))) begin
          mixed_r[g] <= host_wdata;
        end
      end
    end
  endgenerate

  // Standby setting has no host path.
  // It is loaded from the last word; the reset value matches the shipped default.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_r <= DEF_STANDBY_DISABLE;
    end else if (state_r == NCL_LOAD && cnt_r == 3'(NVM_WORDS - 1)) begin
      standby_r <= nvm_rdata[0];
    end
  end

  // Host-only words take fixed reset values; the store never touches them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cable_mon_r  <= RST_CABLE_MON;
      reset_ctrl_r <= RST_RESET_CTRL;
    end else if (idle && host_wr) begin
      if (host_addr == ADDR_CABLE_MON) begin
        cable_mon_r <= host_wdata;
      end
      if (host_addr == ADDR_RESET_CTRL) begin
        reset_ctrl_r <= host_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host read path; a busy loader answers nothing so a host that ignores
  // the init interval sees no ack rather than half-loaded data.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
      host_ack   <= 1'b0;
    end else begin
      host_ack <= idle && (host_wr || host_rd);
      if (idle && host_rd) begin
        host_rdata <= 8'h00;
        for (int i = 0; i < 6; i++) begin
          if (host_addr == idx_addr(3'(i))) begin
            host_rdata <= mixed_r[i];
          end
        end
        if (host_addr == ADDR_CABLE_MON) begin
          host_rdata <= cable_mon_r;
        end
        if (host_addr == ADDR_RESET_CTRL) begin
          host_rdata <= reset_ctrl_r;
        end
      end
    end
  end

  assign load_busy                    = !idle;
  assign standby_disable              = standby_r;
  assign cable_supply_bleed_on        = mixed_r[1][BIT_BLEED_ON];
  assign cable_supply_capability_on   = mixed_r[1][BIT_CAPABILITY_ON];
  assign cable_supply_undervolt_level = cable_mon_r[BIT_UNDERVOLT];
  assign reset_source_select          = reset_ctrl_r[BIT_RESET_SOURCE];
  assign bus_safe_zero_level          = mixed_r[5][LSB_SAFE_ZERO +: 2];

  //////////////////////////////////////////////////////////////////////////////
  // The load-length check is triggered by the release of reset and follows the whole
  // start-up sequence, so a late or short load shows up at once.
  sequence s_release;
    $rose(rst_n);
  endsequence

  // One idle cycle and eight load cycles, so busy covers nine samples.
  sequence s_loading;
    load_busy [*8] ##1 load_busy;
  endsequence

  property p_load_len;
    @(posedge clk) disable iff (!rst_n) s_release |-> s_loading ##1 !load_busy;
  endproperty
  a_load_len: assert property (p_load_len) else $error("Load length wrong");

  property p_busy_blocks;
    @(posedge clk) disable iff (!rst_n) (load_busy && host_wr) |=> !host_ack;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("Ack while loading");

  property p_ack_done;
    @(posedge clk) disable iff (!rst_n) (!load_busy && host_rd) |=> host_ack;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("No ack after load");

  property p_hostonly_reset;
    @(posedge clk) s_release |-> (!reset_source_select && !cable_supply_undervolt_level) [*8];
  endproperty
  a_hostonly_reset: assert property (p_hostonly_reset) else $error("Host-only value wrong");

  property p_bleed_load;
    @(posedge clk) disable iff (!rst_n)
      (state_r == NCL_LOAD && cnt_r == 3'h1) |=> cable_supply_bleed_on == $past(nvm_rdata[BIT_BLEED_ON]);
  endproperty
  a_bleed_load: assert property (p_bleed_load) else $error("Bleed not loaded");

  property p_cap_load;
    @(posedge clk) disable iff (!rst_n)
      (state_r == NCL_LOAD && cnt_r == 3'h1) |=> cable_supply_capability_on == $past(nvm_rdata[BIT_CAPABILITY_ON]);
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("Capability not loaded");

  property p_zero_load;
    @(posedge clk) disable iff (!rst_n)
      (state_r == NCL_LOAD && cnt_r == 3'h5) |=> bus_safe_zero_level == $past(nvm_rdata[2:1]);
  endproperty
  a_zero_load: assert property (p_zero_load) else $error("Safe-zero not loaded");

  property p_host_write;
    @(posedge clk) disable iff (!rst_n)
      (!load_busy && host_wr && host_addr == ADDR_RESET_CTRL) |=> reset_source_select == $past(host_wdata[0]);
  endproperty
  a_host_write: assert property (p_host_write) else $error("Host write lost");

  property p_standby_stable;
    @(posedge clk) disable iff (!rst_n) !load_busy |=> $stable(standby_disable);
  endproperty
  a_standby_stable: assert property (p_standby_stable) else $error("Standby changed");

  property p_standby_load;
    @(posedge clk) disable iff (!rst_n)
      (state_r == NCL_LOAD && cnt_r == 3'(NVM_WORDS - 1)) |=> standby_disable == $past(nvm_rdata[0]);
  endproperty
  a_standby_load: assert property (p_standby_load) else $error("Standby not loaded");

  // A write to the reset control word refused during the load must leave reset_source_select untouched.
  property p_busy_write_dropped;
    @(posedge clk) disable iff (!rst_n)
      (load_busy && host_wr && host_addr == ADDR_RESET_CTRL) |=> $stable(reset_source_select);
  endproperty
  a_busy_write_dropped: assert property (p_busy_write_dropped) else $error("Write taken while loading");

  property p_hostonly_store;
    @(posedge clk) disable iff (!rst_n)
      (state_r == NCL_LOAD) |=> $stable(cable_supply_undervolt_level) && $stable(reset_source_select);
  endproperty
  a_hostonly_store: assert property (p_hostonly_store) else $error("Store touched host-only word");

  // Reset is not disabled here: it is the very event being checked.
  property p_reset_reload;
    @(posedge clk) !rst_n |=> load_busy;
  endproperty
  a_reset_reload: assert property (p_reset_reload) else $error("Reset did not restart load");

endmodule // ncl_loader

//--- common/ncl_pkg.sv
package ncl_pkg;
  // Number of stored words and the width of their address.
  localparam int unsigned NVM_WORDS = 8;
  localparam int unsigned NVM_AW    = 3;

  // Register addresses of the loaded words and the host-only words.
  localparam logic [7:0] ADDR_ALERT_MASK = 8'h0C;
  localparam logic [7:0] ADDR_CABLE_CTRL = 8'h18;
  localparam logic [7:0] ADDR_CABLE_ILIM = 8'h1E;
  localparam logic [7:0] ADDR_CABLE_MON  = 8'h20;
  localparam logic [7:0] ADDR_BUS_SHIFT  = 8'h22;
  localparam logic [7:0] ADDR_RESET_CTRL = 8'h23;
  localparam logic [7:0] ADDR_DISCH_TIME = 8'h25;
  localparam logic [7:0] ADDR_BUS_MON    = 8'h2E;

  // Field positions.
  localparam int unsigned BIT_BLEED_ON      = 0;
  localparam int unsigned BIT_CAPABILITY_ON = 1;
  localparam int unsigned BIT_UNDERVOLT     = 0;
  localparam int unsigned BIT_CABLE_MON_EN  = 1;
  localparam int unsigned BIT_RESET_SOURCE  = 0;
  localparam int unsigned LSB_SAFE_ZERO     = 1;

  // Host-only register reset values.
  localparam logic [7:0] RST_CABLE_MON  = 8'h02;
  localparam logic [7:0] RST_RESET_CTRL = 8'h00;

  // Factory defaults of the store.
  localparam logic [7:0] DEF_ALERT_MASK = 8'h07;
  localparam logic [7:0] DEF_CABLE_CTRL = 8'h02;
  localparam logic [7:0] DEF_CABLE_ILIM = 8'h00;
  localparam logic [7:0] DEF_BUS_SHIFT  = 8'h55;
  localparam logic [7:0] DEF_DISCH_TIME = 8'h6F;
  localparam logic [7:0] DEF_BUS_MON    = 8'h01;
  localparam logic       DEF_STANDBY_DISABLE = 1'b1;

  typedef enum logic [1:0] {
    NCL_IDLE = 2'b00,
    NCL_LOAD = 2'b01,
    NCL_DONE = 2'b11
  } ncl_state_t;
endpackage

//--- sim/ncl_store_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behavioural store: data for the address of one cycle appears in the next.
module ncl_store_model
  import ncl_pkg::*;
(
  // Clock.
  input  wire logic       clk,
  // Read port.
  input  wire logic [2:0] nvm_addr,
  output logic [7:0]      nvm_rdata
);
  import ncl_pkg::*;

  logic [7:0] word_r [NVM_WORDS];

  // Word 6 is unused, so it holds a pattern that no register expects.
  initial begin
    word_r = '{DEF_ALERT_MASK, DEF_CABLE_CTRL, DEF_CABLE_ILIM, DEF_BUS_SHIFT,
               DEF_DISCH_TIME, DEF_BUS_MON, 8'hA5, {7'h00, DEF_STANDBY_DISABLE}};
  end

  always_ff @(posedge clk) begin
    nvm_rdata <= word_r[nvm_addr];
  end
endmodule // ncl_store_model

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ncl_pkg::*;
  logic       clk, rst_n, host_wr, host_rd, host_ack, load_busy, ok;
  logic       standby_disable, bleed, cap, uv, rs;
  logic [1:0] sz;
  logic [2:0] nvm_addr;
  logic [7:0] nvm_rdata, host_addr, host_wdata, host_rdata, got;
  int         fails, check_count;
  logic [7:0] ad [9] = '{ADDR_ALERT_MASK, ADDR_CABLE_CTRL, ADDR_CABLE_ILIM, ADDR_CABLE_MON, ADDR_BUS_SHIFT,
                         ADDR_RESET_CTRL, ADDR_DISCH_TIME, ADDR_BUS_MON, 8'h30};
  logic [7:0] ex [9] = '{DEF_ALERT_MASK, DEF_CABLE_CTRL, DEF_CABLE_ILIM, RST_CABLE_MON, DEF_BUS_SHIFT,
                         RST_RESET_CTRL, DEF_DISCH_TIME, DEF_BUS_MON, 8'h00};

  ncl_store_model u_store (.clk(clk), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata));
  ncl_loader dut (.clk(clk), .rst_n(rst_n), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_ack(host_ack), .load_busy(load_busy), .standby_disable(standby_disable),
    .cable_supply_bleed_on(bleed), .cable_supply_capability_on(cap), .cable_supply_undervolt_level(uv),
    .reset_source_select(rs), .bus_safe_zero_level(sz));

  always #2 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One strobe, then up to four cycles for the acknowledge.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host_wr <= w;
    host_rd <= !w;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1 ok = (host_ack === 1'b1);
      got = host_rdata;
      if (!ok) @(posedge clk);
    end
  endtask

  // A write tried during the load must be dropped without an acknowledge.
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b1, ADDR_RESET_CTRL, 8'h01);
    chk("early ack", {7'h00, ok}, 8'h00);
    #1;
    chk("busy in load", {7'h00, load_busy}, 8'h01);
    for (int i = 0; i < 40 && load_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("load_busy", {7'h00, load_busy}, 8'h00);
  endtask

  task automatic check_defaults;
    chk("config", {1'b0, standby_disable, bleed, cap, uv, rs, sz}, 8'h50);
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, ad[i], 8'h00);
      chk("read ack", {7'h00, ok}, 8'h01);
      chk("read data", got, ex[i]);
    end
    $display("test defaults done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    fails = 0;
    check_count = 0;
    do_reset;
    check_defaults;
    acc(1'b1, ADDR_CABLE_CTRL, 8'h01);
    acc(1'b1, ADDR_CABLE_MON, 8'h03);
    acc(1'b1, ADDR_RESET_CTRL, 8'h01);
    acc(1'b1, ADDR_BUS_MON, 8'h07);
    acc(1'b1, 8'h30, 8'hFF);
    chk("unmapped write ack", {7'h00, ok}, 8'h01);
    chk("config", {1'b0, standby_disable, bleed, cap, uv, rs, sz}, 8'h6F);
    acc(1'b0, ADDR_CABLE_CTRL, 8'h00);
    chk("cable ctrl", got, 8'h01);
    acc(1'b0, ADDR_BUS_MON, 8'h00);
    chk("bus mon", got, 8'h07);
    acc(1'b0, 8'h30, 8'h00);
    chk("unmapped read", got, 8'h00);
    $display("test host writes done");
    do_reset;
    check_defaults;
    final_report;
  end

  // The tests need well under two thousand cycles.
  initial begin
    #20000;
    fails++;
    final_report;
  end
endmodule // testbench
